/* hw/rfir_regs.sv */
// top of the regulator fault interrupt registers: decode, live inputs, pin
// assumes live fault levels synchronous to clk and a never-waiting register port
module rfir_regs (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rdata,
    input wire logic buck3_fault_live,
    input wire logic buck2_fault_live,
    input wire logic buck1_phase_b_live,
    input wire logic buck1_phase_a_live,
    input wire logic fuse_error_live,
    input wire logic fuse_program_running_live,
    input wire logic input_overvoltage_live,
    input wire logic boost_fault_live,
    output logic interrupt_request_pin_b
);
    rfir_group_if g1 ();
    rfir_group_if g3 ();

    logic [7:0] sense1;
    logic [7:0] sense3;
    logic [7:0] set1;
    logic [7:0] set3;
    logic fuse_run_q;
    logic next_fuse_run_q;
    logic fuse_done_evt;
    logic [7:0] next_rdata;
    logic [7:0] read_mux;

    // sense bits are wires from the detectors, so a reset shows the true state
    always_comb
    begin
        sense1 = '0;
        sense1[rfir_pkg::RFIR_BUCK3_BIT] = buck3_fault_live;
        sense1[rfir_pkg::RFIR_BUCK2_BIT] = buck2_fault_live;
        sense1[rfir_pkg::RFIR_BUCK1B_BIT] = buck1_phase_b_live;
        sense1[rfir_pkg::RFIR_BUCK1A_BIT] = buck1_phase_a_live;
    end

    always_comb
    begin
        sense3 = '0;
        sense3[rfir_pkg::RFIR_FUSE_ERR_BIT] = fuse_error_live;
        sense3[rfir_pkg::RFIR_FUSE_DONE_BIT] = fuse_program_running_live;
        sense3[rfir_pkg::RFIR_OVERVOLT_BIT] = input_overvoltage_live;
        sense3[rfir_pkg::RFIR_BOOST_BIT] = boost_fault_live;
    end

    // completion is the falling edge of the running level
    always_comb
    begin
        next_fuse_run_q = fuse_program_running_live;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            fuse_run_q <= 1'b0;
        end
        else if (ce)
        begin
            fuse_run_q <= next_fuse_run_q;
        end
    end

    assign fuse_done_evt = fuse_run_q & ~fuse_program_running_live;

    // level faults keep setting their flag for as long as they last
    always_comb
    begin
        set1 = '0;
        set1[rfir_pkg::RFIR_BUCK3_BIT] = buck3_fault_live;
        set1[rfir_pkg::RFIR_BUCK2_BIT] = buck2_fault_live;
        set1[rfir_pkg::RFIR_BUCK1B_BIT] = buck1_phase_b_live;
        set1[rfir_pkg::RFIR_BUCK1A_BIT] = buck1_phase_a_live;
    end

    always_comb
    begin
        set3 = '0;
        set3[rfir_pkg::RFIR_FUSE_ERR_BIT] = fuse_error_live;
        set3[rfir_pkg::RFIR_FUSE_DONE_BIT] = fuse_done_evt;
        set3[rfir_pkg::RFIR_OVERVOLT_BIT] = input_overvoltage_live;
        set3[rfir_pkg::RFIR_BOOST_BIT] = boost_fault_live;
    end

    assign g1.set_req = set1;
    assign g3.set_req = set3;
    assign g1.wdata = wdata;
    assign g3.wdata = wdata;
    assign g1.wr_status = wr_stb && (addr == rfir_pkg::RFIR_BUCK_FAULT_STATUS);
    assign g1.wr_mask = wr_stb && (addr == rfir_pkg::RFIR_BUCK_FAULT_MASK);
    assign g3.wr_status = wr_stb && (addr == rfir_pkg::RFIR_FUSE_BOOST_INPUT_STATUS);
    assign g3.wr_mask = wr_stb && (addr == rfir_pkg::RFIR_FUSE_BOOST_INPUT_MASK);

    rfir_group #(
        .IMPL(rfir_pkg::RFIR_G1_IMPL),
        .MASK_RST(rfir_pkg::RFIR_G1_MASK_RST)
    ) u_group1 (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .g(g1.grp)
    );

    rfir_group #(
        .IMPL(rfir_pkg::RFIR_G3_IMPL),
        .MASK_RST(rfir_pkg::RFIR_G3_MASK_RST)
    ) u_group3 (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .g(g3.grp)
    );

    // sense writes fall through the decode and are dropped
    always_comb
    begin
        unique case (addr)
            rfir_pkg::RFIR_BUCK_FAULT_STATUS: read_mux = g1.status;
            rfir_pkg::RFIR_BUCK_FAULT_MASK: read_mux = g1.mask;
            rfir_pkg::RFIR_BUCK_FAULT_SENSE: read_mux = sense1;
            rfir_pkg::RFIR_FUSE_BOOST_INPUT_STATUS: read_mux = g3.status;
            rfir_pkg::RFIR_FUSE_BOOST_INPUT_MASK: read_mux = g3.mask;
            rfir_pkg::RFIR_FUSE_BOOST_INPUT_SENSE: read_mux = sense3;
            default: read_mux = '0;
        endcase
    end

    // read data is shown for exactly one cycle, zero otherwise
    always_comb
    begin
        next_rdata = rfir_pkg::RFIR_RDATA_RST;
        if (rd_stb)
        begin
            next_rdata = read_mux;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rdata <= rfir_pkg::RFIR_RDATA_RST;
        end
        else if (ce)
        begin
            rdata <= next_rdata;
        end
    end

    // pin is gated straight from flops, one level per group, no extra lag
    assign interrupt_request_pin_b = ~(g1.pending | g3.pending);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    chk_buck3_sets: assert property (
        ce && buck3_fault_live |=> g1.status[rfir_pkg::RFIR_BUCK3_BIT])
        else $error("buck three fault did not set its flag");

    chk_buck2_sets: assert property (
        ce && buck2_fault_live |=> g1.status[rfir_pkg::RFIR_BUCK2_BIT])
        else $error("buck two fault did not set its flag");

    chk_buck1b_sets: assert property (
        ce && buck1_phase_b_live |=> g1.status[rfir_pkg::RFIR_BUCK1B_BIT])
        else $error("buck one phase b fault did not set its flag");

    chk_buck1a_sets: assert property (
        ce && buck1_phase_a_live |=> g1.status[rfir_pkg::RFIR_BUCK1A_BIT])
        else $error("buck one phase a fault did not set its flag");

    chk_zero_keeps_flags: assert property (
        ce && g1.wr_status |=>
        ((g1.status & $past(g1.status) & ~$past(wdata))
            == ($past(g1.status) & ~$past(wdata))))
        else $error("writing zero disturbed a flag");

    chk_one_clears_flag: assert property (
        ce && g3.wr_status && wdata[rfir_pkg::RFIR_BOOST_BIT] && !boost_fault_live
        |=> !g3.status[rfir_pkg::RFIR_BOOST_BIT])
        else $error("write one did not clear the flag");

    chk_flag_sticky: assert property (
        ce && g1.status[rfir_pkg::RFIR_BUCK2_BIT] && !g1.wr_status
        |=> g1.status[rfir_pkg::RFIR_BUCK2_BIT])
        else $error("flag dropped without a clear");

    chk_unmask_fires: assert property (
        ce && g1.wr_mask && !wdata[rfir_pkg::RFIR_BUCK3_BIT]
        && g1.status[rfir_pkg::RFIR_BUCK3_BIT] && !g1.wr_status
        |=> !interrupt_request_pin_b)
        else $error("unmasked flag did not reach the pin");

    chk_all_masked_quiet: assert property (
        (g1.mask == rfir_pkg::RFIR_G1_IMPL) && (g3.mask == rfir_pkg::RFIR_G3_IMPL)
        |-> interrupt_request_pin_b)
        else $error("masked flags pulled the pin");

    chk_mask1_layout: assert property (
        ce && g1.wr_mask |=> g1.mask == ($past(wdata) & rfir_pkg::RFIR_G1_IMPL))
        else $error("group one mask holds wrong bits");

    chk_sense_follows: assert property (
        ce && rd_stb && (addr == rfir_pkg::RFIR_BUCK_FAULT_SENSE) && !(|sense1)
        |=> rdata == rfir_pkg::RFIR_RDATA_RST)
        else $error("sense read shows a latched value");

    chk_sense1_read: assert property (
        ce && rd_stb && (addr == rfir_pkg::RFIR_BUCK_FAULT_SENSE)
        |=> rdata == $past(sense1))
        else $error("group one sense read wrong");

    chk_sense_unwritable: assert property (
        ce && wr_stb && (addr == rfir_pkg::RFIR_BUCK_FAULT_SENSE)
        |=> ((g1.status & ~$past(set1)) == ($past(g1.status) & ~$past(set1)))
        && $stable(g1.mask))
        else $error("sense write changed state");

    chk_sense3_unwritable: assert property (
        ce && wr_stb && (addr == rfir_pkg::RFIR_FUSE_BOOST_INPUT_SENSE)
        |=> ((g3.status & ~$past(set3)) == ($past(g3.status) & ~$past(set3)))
        && $stable(g3.mask))
        else $error("group three sense write changed state");

    // unmapped offsets must not alias a real register
    chk_unmapped_zero: assert property (
        ce && rd_stb && (addr > rfir_pkg::RFIR_FUSE_BOOST_INPUT_SENSE)
        |=> rdata == rfir_pkg::RFIR_RDATA_RST)
        else $error("unmapped read returned data");

    chk_fuse_run_sense: assert property (
        ce && rd_stb && (addr == rfir_pkg::RFIR_FUSE_BOOST_INPUT_SENSE)
        && fuse_program_running_live |=> rdata[rfir_pkg::RFIR_FUSE_DONE_BIT])
        else $error("fuse running not shown on sense");

    chk_sense_no_lag: assert property (
        ce && rd_stb && (addr == rfir_pkg::RFIR_FUSE_BOOST_INPUT_SENSE)
        && boost_fault_live |=> rdata[rfir_pkg::RFIR_BOOST_BIT])
        else $error("sense did not show the live boost state");

    chk_fuse_err_sets: assert property (
        ce && fuse_error_live |=> g3.status[rfir_pkg::RFIR_FUSE_ERR_BIT])
        else $error("fuse error did not set its flag");

    chk_fuse_done_sets: assert property (
        ce && fuse_program_running_live ##1 ce && !fuse_program_running_live
        |=> g3.status[rfir_pkg::RFIR_FUSE_DONE_BIT])
        else $error("fuse program end did not set its flag");

    chk_fuse_done_quiet: assert property (
        ce && !g3.status[rfir_pkg::RFIR_FUSE_DONE_BIT] && !fuse_done_evt
        |=> !g3.status[rfir_pkg::RFIR_FUSE_DONE_BIT])
        else $error("fuse done flag set without completion");

    chk_overvolt_sets: assert property (
        ce && input_overvoltage_live |=> g3.status[rfir_pkg::RFIR_OVERVOLT_BIT])
        else $error("overvoltage did not set its flag");

    chk_boost_sets: assert property (
        ce && boost_fault_live |=> g3.status[rfir_pkg::RFIR_BOOST_BIT])
        else $error("boost fault did not set its flag");

    chk_mask3_layout: assert property (
        ce && g3.wr_mask |=> g3.mask == ($past(wdata) & rfir_pkg::RFIR_G3_IMPL))
        else $error("group three mask holds wrong bits");

    chk_sense3_read: assert property (
        ce && rd_stb && (addr == rfir_pkg::RFIR_FUSE_BOOST_INPUT_SENSE)
        |=> rdata == $past(sense3))
        else $error("group three sense read wrong");

    chk_irq_has_cause: assert property (
        !interrupt_request_pin_b |->
        (|(g1.status & ~g1.mask)) || (|(g3.status & ~g3.mask)))
        else $error("pin asserted with no unmasked flag");

    chk_irq_releases: assert property (
        ce && g1.wr_status && ((wdata & rfir_pkg::RFIR_G1_IMPL) == rfir_pkg::RFIR_G1_IMPL)
        && !(|set1)
        && (g3.status == rfir_pkg::RFIR_STATUS_RST) && !(|set3)
        |=> interrupt_request_pin_b)
        else $error("pin held after last flag cleared");

    chk_read_one_cycle: assert property (
        ce && !rd_stb |=> rdata == rfir_pkg::RFIR_RDATA_RST)
        else $error("read data outside its cycle");

    chk_g1_irq_fires: assert property (
        (|(g1.status & ~g1.mask)) |-> !interrupt_request_pin_b)
        else $error("unmasked group one flag left the pin idle");

    chk_g3_irq_fires: assert property (
        (|(g3.status & ~g3.mask)) |-> !interrupt_request_pin_b)
        else $error("unmasked group three flag left the pin idle");

    chk_none_pending_idle: assert property (
        ((g1.status & ~g1.mask) == rfir_pkg::RFIR_STATUS_RST)
        && ((g3.status & ~g3.mask) == rfir_pkg::RFIR_STATUS_RST)
        |-> interrupt_request_pin_b)
        else $error("pin asserted by masked flags");

    // a frozen block must not lose a flag or a mask
    chk_freeze_holds: assert property (
        !ce |=> $stable(g1.status) && $stable(g3.status)
        && $stable(g1.mask) && $stable(g3.mask))
        else $error("state moved while frozen");

    cov_irq_release: cover property (
        !interrupt_request_pin_b ##1 interrupt_request_pin_b);

    cov_buck_fault_irq: cover property (
        ce && buck3_fault_live ##1 !interrupt_request_pin_b);

    cov_clear_set_race: cover property (
        ce && g1.wr_status && wdata[rfir_pkg::RFIR_BUCK2_BIT] && buck2_fault_live);

    cov_fuse_done: cover property (
        ce && fuse_done_evt);

    cov_sense_read: cover property (
        ce && rd_stb && (addr == rfir_pkg::RFIR_FUSE_BOOST_INPUT_SENSE) && (|sense3));
endmodule : rfir_regs

/* hw/rfir_pkg.sv */
// constants shared by the regulator fault interrupt register block
// assumes one byte-wide register port and live fault levels synchronous to clk
package rfir_pkg;
    localparam int RFIR_ADDR_W = 8;
    localparam int RFIR_DATA_W = 8;

    // register offsets
    localparam logic [7:0] RFIR_BUCK_FAULT_STATUS = 8'h00;
    localparam logic [7:0] RFIR_BUCK_FAULT_MASK = 8'h01;
    localparam logic [7:0] RFIR_BUCK_FAULT_SENSE = 8'h02;
    localparam logic [7:0] RFIR_FUSE_BOOST_INPUT_STATUS = 8'h03;
    localparam logic [7:0] RFIR_FUSE_BOOST_INPUT_MASK = 8'h04;
    localparam logic [7:0] RFIR_FUSE_BOOST_INPUT_SENSE = 8'h05;

    // group one field positions
    localparam int RFIR_BUCK3_BIT = 4;
    localparam int RFIR_BUCK2_BIT = 3;
    localparam int RFIR_BUCK1B_BIT = 1;
    localparam int RFIR_BUCK1A_BIT = 0;

    // group three field positions
    localparam int RFIR_FUSE_ERR_BIT = 7;
    localparam int RFIR_FUSE_DONE_BIT = 6;
    localparam int RFIR_OVERVOLT_BIT = 2;
    localparam int RFIR_BOOST_BIT = 0;

    // implemented bits, everything else reads zero
    localparam logic [7:0] RFIR_G1_IMPL = 8'h1B;
    localparam logic [7:0] RFIR_G3_IMPL = 8'hC5;

    // masks come up masked so nothing fires before software sets up
    localparam logic [7:0] RFIR_G1_MASK_RST = 8'h1B;
    localparam logic [7:0] RFIR_G3_MASK_RST = 8'hC5;
    localparam logic [7:0] RFIR_STATUS_RST = 8'h00;
    localparam logic [7:0] RFIR_RDATA_RST = 8'h00;
endpackage : rfir_pkg

/* hw/rfir_group_if.sv */
// carrier between the top and one status/mask group
// assumes the top raises set requests and decodes the register strobes
interface rfir_group_if;
    logic [rfir_pkg::RFIR_DATA_W-1:0] set_req;
    logic [rfir_pkg::RFIR_DATA_W-1:0] wdata;
    logic wr_status;
    logic wr_mask;
    logic [rfir_pkg::RFIR_DATA_W-1:0] status;
    logic [rfir_pkg::RFIR_DATA_W-1:0] mask;
    logic pending;

    modport top (
        output set_req,
        output wdata,
        output wr_status,
        output wr_mask,
        input status,
        input mask,
        input pending
    );
    modport grp (
        input set_req,
        input wdata,
        input wr_status,
        input wr_mask,
        output status,
        output mask,
        output pending
    );
endinterface : rfir_group_if

/* hw/rfir_group.sv */
// one group of sticky fault flags with its mask register
// assumes strobes are one cycle and already qualified by address
module rfir_group #(
    parameter logic [7:0] IMPL = 8'h00,
    parameter logic [7:0] MASK_RST = 8'h00
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    rfir_group_if.grp g
);
    logic [rfir_pkg::RFIR_DATA_W-1:0] next_status;
    logic [rfir_pkg::RFIR_DATA_W-1:0] next_mask;

    // set beats a same-cycle write-one clear
    genvar i;
    generate
        for (i = 0; i < rfir_pkg::RFIR_DATA_W; i++)
        begin : g_flag
            assign next_status[i] = IMPL[i]
                & (g.set_req[i] | (g.status[i] & ~(g.wr_status & g.wdata[i])));
        end
    endgenerate

    always_comb
    begin
        next_mask = g.mask;
        if (g.wr_mask)
        begin
            next_mask = g.wdata & IMPL;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            g.status <= rfir_pkg::RFIR_STATUS_RST;
            g.mask <= MASK_RST;
        end
        else if (ce)
        begin
            g.status <= next_status;
            g.mask <= next_mask;
        end
    end

    // a zero mask bit lets its flag through
    assign g.pending = |(g.status & ~g.mask);
endmodule : rfir_group

/* bench/rfir_host_model.sv */
// host side of the fault register block: byte register port master
// assumes a slave that never waits and answers a read one cycle later
module rfir_host_model (
    input wire logic clk,
    output logic [7:0] addr,
    output logic [7:0] wdata,
    output logic wr_stb,
    output logic rd_stb,
    input wire logic [7:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        addr = 8'h00;
        wdata = 8'h00;
        wr_stb = 1'h0;
        rd_stb = 1'h0;
    end

    // any offset is driven as given, the bench also reads the unmapped offset 8'h06
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'h1;
        @(posedge clk);
        wr_stb <= 1'h0;
        // idle bus shows the inverse so a stale value cannot pass
        addr <= ~a;
        wdata <= ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'h1;
        @(posedge clk);
        rd_stb <= 1'h0;
        addr <= ~a;
        // data stand only until the next edge
        #1;
        d = rdata;
    endtask : rd
endmodule : rfir_host_model

/* bench/rfir_regs_test.sv */
// self-checking bench of the fault register block
// assumes fault levels driven here, register port driven by the host model
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_mismatch++; \
    $display("ERROR %0t: got %h want %h", $time, (a), (e)); end end
module rfir_regs_test;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [7:0] lv1;
        logic [7:0] lv3;
        logic [7:0] m1;
        logic [7:0] m3;
        logic [7:0] s1;
        logic [7:0] s3;
        logic pin;
    } rfir_row_t;

    logic clk = 1'h0;
    logic rst_b = 1'h0;
    logic ce = 1'h1;
    logic [7:0] lv1 = 8'h02;
    logic [7:0] lv3 = 8'h00;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr_stb;
    logic rd_stb;
    logic [7:0] rdata;
    logic pin_b;
    logic [7:0] d;
    int n_mismatch = 0;
    int compares = 0;
    rfir_row_t r;
    rfir_row_t rows [9] = '{
        '{8'h10, 8'h00, 8'h00, 8'hC5, 8'h10, 8'h00, 1'h0},
        '{8'h08, 8'h00, 8'h1B, 8'hC5, 8'h08, 8'h00, 1'h1},
        '{8'h02, 8'h00, 8'h19, 8'hC5, 8'h02, 8'h00, 1'h0},
        '{8'h01, 8'h00, 8'h1A, 8'hC5, 8'h01, 8'h00, 1'h0},
        '{8'h1B, 8'h00, 8'hFF, 8'hC5, 8'h1B, 8'h00, 1'h1},
        '{8'h00, 8'h80, 8'h1B, 8'h45, 8'h00, 8'h80, 1'h0},
        '{8'h00, 8'h04, 8'h1B, 8'hC1, 8'h00, 8'h04, 1'h0},
        '{8'h00, 8'h01, 8'h1B, 8'hC5, 8'h00, 8'h01, 1'h1},
        '{8'h00, 8'h85, 8'h1B, 8'hC4, 8'h00, 8'h85, 1'h0}
    };

    always #20 clk = ~clk;

    rfir_regs rfir_regs_i (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .addr(addr),
        .wdata(wdata),
        .wr_stb(wr_stb),
        .rd_stb(rd_stb),
        .rdata(rdata),
        .buck3_fault_live(lv1[4]),
        .buck2_fault_live(lv1[3]),
        .buck1_phase_b_live(lv1[1]),
        .buck1_phase_a_live(lv1[0]),
        .fuse_error_live(lv3[7]),
        .fuse_program_running_live(lv3[6]),
        .input_overvoltage_live(lv3[2]),
        .boost_fault_live(lv3[0]),
        .interrupt_request_pin_b(pin_b)
    );

    rfir_host_model rfir_host_model_i (
        .clk(clk),
        .addr(addr),
        .wdata(wdata),
        .wr_stb(wr_stb),
        .rd_stb(rd_stb),
        .rdata(rdata)
    );

    task automatic give_verdict;
        if (n_mismatch == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : give_verdict

    task automatic pulse1(input logic [7:0] v);
        @(posedge clk);
        lv1 <= v;
        @(posedge clk);
        lv1 <= 8'h00;
    endtask : pulse1

    initial
    begin
        repeat (50000) @(posedge clk);
        n_mismatch++;
        give_verdict();
    end

    initial
    begin
        repeat (9) @(posedge clk);
        #1;
        `CHK(pin_b, 1'h1)
        @(posedge clk);
        rst_b <= 1'h1;
        rfir_host_model_i.rd(rfir_pkg::RFIR_BUCK_FAULT_SENSE, d);
        `CHK(d, 8'h02)
        lv1 <= 8'h00;
        rfir_host_model_i.rd(rfir_pkg::RFIR_BUCK_FAULT_MASK, d);
        `CHK(d, 8'h1B)
        rfir_host_model_i.rd(rfir_pkg::RFIR_FUSE_BOOST_INPUT_MASK, d);
        `CHK(d, 8'hC5)
        rfir_host_model_i.rd(rfir_pkg::RFIR_FUSE_BOOST_INPUT_STATUS, d);
        `CHK(d, 8'h00)
        rfir_host_model_i.rd(8'h06, d);
        `CHK(d, 8'h00)
        for (int i = 0; i < 9; i++)
        begin
            r = rows[i];
            rfir_host_model_i.wr(rfir_pkg::RFIR_BUCK_FAULT_MASK, r.m1);
            rfir_host_model_i.wr(rfir_pkg::RFIR_FUSE_BOOST_INPUT_MASK, r.m3);
            rfir_host_model_i.wr(rfir_pkg::RFIR_BUCK_FAULT_STATUS, 8'hFF);
            rfir_host_model_i.wr(rfir_pkg::RFIR_FUSE_BOOST_INPUT_STATUS, 8'hFF);
            rfir_host_model_i.rd(rfir_pkg::RFIR_BUCK_FAULT_MASK, d);
            `CHK(d, r.m1 & rfir_pkg::RFIR_G1_IMPL)
            @(posedge clk);
            lv1 <= r.lv1;
            lv3 <= r.lv3;
            rfir_host_model_i.rd(rfir_pkg::RFIR_BUCK_FAULT_SENSE, d);
            `CHK(d, r.lv1)
            rfir_host_model_i.rd(rfir_pkg::RFIR_FUSE_BOOST_INPUT_SENSE, d);
            `CHK(d, r.lv3)
            @(posedge clk);
            lv1 <= 8'h00;
            lv3 <= 8'h00;
            rfir_host_model_i.rd(rfir_pkg::RFIR_FUSE_BOOST_INPUT_SENSE, d);
            `CHK(d, 8'h00)
            rfir_host_model_i.rd(rfir_pkg::RFIR_BUCK_FAULT_STATUS, d);
            `CHK(d, r.s1)
            rfir_host_model_i.rd(rfir_pkg::RFIR_FUSE_BOOST_INPUT_STATUS, d);
            `CHK(d, r.s3)
            `CHK(pin_b, r.pin)
        end
        // writing zero or other bits keeps a flag, its own one clears it only once the fault is gone
        rfir_host_model_i.wr(rfir_pkg::RFIR_FUSE_BOOST_INPUT_STATUS, 8'hFF);
        pulse1(8'h08);
        rfir_host_model_i.wr(rfir_pkg::RFIR_BUCK_FAULT_STATUS, 8'hF7);
        rfir_host_model_i.rd(rfir_pkg::RFIR_BUCK_FAULT_STATUS, d);
        `CHK(d, 8'h08)
        @(posedge clk);
        lv1 <= 8'h08;
        rfir_host_model_i.wr(rfir_pkg::RFIR_BUCK_FAULT_STATUS, 8'h08);
        rfir_host_model_i.rd(rfir_pkg::RFIR_BUCK_FAULT_STATUS, d);
        `CHK(d, 8'h08)
        lv1 <= 8'h02;
        rfir_host_model_i.wr(rfir_pkg::RFIR_BUCK_FAULT_SENSE, 8'h00);
        rfir_host_model_i.rd(rfir_pkg::RFIR_BUCK_FAULT_SENSE, d);
        `CHK(d, 8'h02)
        lv1 <= 8'h00;
        rfir_host_model_i.wr(rfir_pkg::RFIR_BUCK_FAULT_STATUS, 8'hFF);
        rfir_host_model_i.rd(rfir_pkg::RFIR_BUCK_FAULT_STATUS, d);
        `CHK(d, 8'h00)
        // fuse programming runs, then its completion raises the done flag
        @(posedge clk);
        lv3 <= 8'h40;
        rfir_host_model_i.rd(rfir_pkg::RFIR_FUSE_BOOST_INPUT_SENSE, d);
        `CHK(d, 8'h40)
        rfir_host_model_i.rd(rfir_pkg::RFIR_FUSE_BOOST_INPUT_STATUS, d);
        `CHK(d, 8'h00)
        lv3 <= 8'h00;
        rfir_host_model_i.rd(rfir_pkg::RFIR_FUSE_BOOST_INPUT_STATUS, d);
        `CHK(d, 8'h40)
        `CHK(pin_b, 1'h1)
        rfir_host_model_i.wr(rfir_pkg::RFIR_FUSE_BOOST_INPUT_MASK, 8'hBF);
        #1;
        `CHK(pin_b, 1'h0)
        rfir_host_model_i.wr(rfir_pkg::RFIR_FUSE_BOOST_INPUT_STATUS, 8'h40);
        #1;
        `CHK(pin_b, 1'h1)
        // a frozen block drops strobes
        @(posedge clk);
        ce <= 1'h0;
        rfir_host_model_i.wr(rfir_pkg::RFIR_BUCK_FAULT_MASK, 8'h00);
        ce <= 1'h1;
        rfir_host_model_i.rd(rfir_pkg::RFIR_BUCK_FAULT_MASK, d);
        `CHK(d, 8'h1B)
        // second reset in mid-run brings the masks back
        rfir_host_model_i.wr(rfir_pkg::RFIR_FUSE_BOOST_INPUT_MASK, 8'h00);
        pulse1(8'h01);
        @(posedge clk);
        rst_b <= 1'h0;
        #1;
        `CHK(pin_b, 1'h1)
        @(posedge clk);
        rst_b <= 1'h1;
        rfir_host_model_i.rd(rfir_pkg::RFIR_FUSE_BOOST_INPUT_MASK, d);
        `CHK(d, 8'hC5)
        give_verdict();
    end
endmodule : rfir_regs_test
